/* src/fmr_defs.svh */
// Byte codes, frame offsets and field values of the two fast meter responses.
// Included by the framer; holds definitions only.
`ifndef FMR_DEFS_SVH
`define FMR_DEFS_SVH

`define FMR_SYNC_BYTE      8'hA5
`define FMR_CFG_CODE       8'hC1
`define FMR_DAT_CODE       8'hD1
`define FMR_CFG_LEN        8'hDE
`define FMR_DAT_LEN        8'hEA

// Configuration block field values
`define FMR_STAT_FLAG_CNT  8'h01
`define FMR_NO_SCALE       8'h00
`define FMR_SCALE_CNT      8'h00
`define FMR_ANALOG_CNT     8'h13
`define FMR_SAMPLE_CNT     8'h02
`define FMR_BANK_CNT       8'h44
`define FMR_CALC_CNT       8'h01
`define FMR_ANALOG_OFS     16'h0004
`define FMR_TSTAMP_OFS     16'h009C
`define FMR_DIGITAL_OFS    16'h00A4
`define FMR_TYPE_FLOAT     8'h01
`define FMR_SCALE_TYPE     8'hFF
`define FMR_SCALE_OFS      16'h0000
`define FMR_LINE_ROT       8'h00
`define FMR_POWER_CALC     8'h00
`define FMR_NOT_USED       8'hFF
`define FMR_IDX_IA         8'h00
`define FMR_IDX_IB         8'h01
`define FMR_IDX_IC         8'h02
`define FMR_IDX_VA         8'h04
`define FMR_IDX_VB         8'h05
`define FMR_IDX_VC         8'h06
`define FMR_RESERVED       8'h00

// Byte positions within the configuration block
`define FMR_CFG_DESC_FIRST 8'h10
`define FMR_CFG_DESC_LAST  8'hCD
`define FMR_CFG_CALC_FIRST 8'hCE
`define FMR_CFG_SUM_IDX    8'hDD
`define FMR_DESC_LEN       8'h0A
`define FMR_NAME_LEN       8'h06

// Byte positions within the data block
`define FMR_DAT_SRC_FIRST  8'h03
`define FMR_DAT_RSV_IDX    8'hE8
`define FMR_DAT_SUM_IDX    8'hE9

`endif

/* src/fmr_pkg.sv */
// Types shared by the fast meter response framer.
// No dependencies.
package fmr_pkg;

    typedef enum logic [2:0] {
        SEND_IDLE  = 3'b001,
        SEND_FETCH = 3'b010,
        SEND_LOAD  = 3'b100
    } fmr_send_e;

    typedef enum logic [1:0] {
        PARSE_SYNC = 2'b01,
        PARSE_CODE = 2'b10
    } fmr_parse_e;

endpackage

/* src/fmr_framer.sv */
// Fast meter response framer: decodes two-byte binary requests and streams the
// configuration or data block, interleaving with a pass-through ASCII stream.
// Assumes a byte-wide receiver and transmitter on REF_CLK, and a payload source
// that answers SRC_ADDR with SRC_DATA within the same clock cycle as the read.
// Summary of operation
// RULE1 - Config reply starts A5C1, length DE
// RULE2 - Status flag count, no scale factors
// RULE3 - Thirteen hex channels, two samples each
// RULE4 - Forty-four hex banks, one calculation block
// RULE5 - Offsets 0004, 009C, 00A4 in order
// RULE6 - Descriptor: name, float type, FF, 0000
// RULE7 - Fixed nineteen-channel descriptor order
// RULE8 - Calculation block fields and channel indices
// RULE9 - Both blocks end with checksum byte
// RULE10 - Data reply starts A5D1, length EA
// RULE11 - 152 float bytes follow status byte
// RULE12 - Time stamp, banks, reserved, checksum
// RULE13 - Binary burst interrupts, ASCII then resumes
// RULE14 - Checksum is eight-bit sum
// RULE15 - Host sends code, awaits full reply
`include "fmr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module fmr_framer (
    input  wire logic       REF_CLK,
    input  wire logic       RESETN,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_VALID,
    input  wire logic [7:0] ASCII_DATA,
    input  wire logic       ASCII_VALID,
    output logic            ASCII_READY,
    output logic [7:0]      TX_DATA,
    output logic            TX_VALID,
    input  wire logic       TX_READY,
    output logic [7:0]      SRC_ADDR,
    output logic            SRC_RD,
    input  wire logic [7:0] SRC_DATA,
    output logic            BURST_ACTIVE
);

    // Six ASCII bytes of each channel name, zero padded
    function automatic logic [47:0] chan_name(input logic [4:0] ch);
        unique case (ch)
            5'h00:   chan_name = 48'h494100000000;
            5'h01:   chan_name = 48'h494200000000;
            5'h02:   chan_name = 48'h494300000000;
            5'h03:   chan_name = 48'h495000000000;
            5'h04:   chan_name = 48'h564100000000;
            5'h05:   chan_name = 48'h564200000000;
            5'h06:   chan_name = 48'h564300000000;
            5'h07:   chan_name = 48'h565300000000;
            5'h08:   chan_name = 48'h465245510000;
            5'h09:   chan_name = 48'h564241540000;
            5'h0A:   chan_name = 48'h494158000000;
            5'h0B:   chan_name = 48'h494258000000;
            5'h0C:   chan_name = 48'h494358000000;
            5'h0D:   chan_name = 48'h494159000000;
            5'h0E:   chan_name = 48'h494259000000;
            5'h0F:   chan_name = 48'h494359000000;
            5'h10:   chan_name = 48'h494154000000;
            5'h11:   chan_name = 48'h494254000000;
            5'h12:   chan_name = 48'h494354000000;
            default: chan_name = 48'h000000000000;
        endcase
    endfunction

    // Byte of the configuration block at a given position, checksum excluded
    function automatic logic [7:0] cfg_byte(input logic [7:0] idx);
        logic [7:0]  d;
        logic [4:0]  ch;
        logic [3:0]  k;
        logic [47:0] nm;
        d  = idx - `FMR_CFG_DESC_FIRST;
        ch = 5'(d / `FMR_DESC_LEN);
        k  = 4'(d % `FMR_DESC_LEN);
        nm = chan_name(ch);
        cfg_byte = `FMR_RESERVED;
        if (idx >= `FMR_CFG_DESC_FIRST && idx <= `FMR_CFG_DESC_LAST) begin
            if (k < 4'(`FMR_NAME_LEN)) begin
                cfg_byte = 8'(nm >> (6'(5 - k) * 6'h08));                // [RULE7]
            end else if (k == 4'h6) begin
                cfg_byte = `FMR_TYPE_FLOAT;                              // [RULE6]
            end else if (k == 4'h7) begin
                cfg_byte = `FMR_SCALE_TYPE;                              // [RULE6]
            end else if (k == 4'h8) begin
                cfg_byte = 8'(`FMR_SCALE_OFS >> 8);                      // [RULE6]
            end else begin
                cfg_byte = 8'(`FMR_SCALE_OFS);                           // [RULE6]
            end
        end else begin
            unique case (idx)
                8'h00: cfg_byte = `FMR_SYNC_BYTE;                        // [RULE1]
                8'h01: cfg_byte = `FMR_CFG_CODE;                         // [RULE1]
                8'h02: cfg_byte = `FMR_CFG_LEN;                          // [RULE1]
                8'h03: cfg_byte = `FMR_STAT_FLAG_CNT;                    // [RULE2]
                8'h04: cfg_byte = `FMR_NO_SCALE;                         // [RULE2]
                8'h05: cfg_byte = `FMR_SCALE_CNT;                        // [RULE2]
                8'h06: cfg_byte = `FMR_ANALOG_CNT;                       // [RULE3]
                8'h07: cfg_byte = `FMR_SAMPLE_CNT;                       // [RULE3]
                8'h08: cfg_byte = `FMR_BANK_CNT;                         // [RULE4]
                8'h09: cfg_byte = `FMR_CALC_CNT;                         // [RULE4]
                8'h0A: cfg_byte = 8'(`FMR_ANALOG_OFS >> 8);              // [RULE5]
                8'h0B: cfg_byte = 8'(`FMR_ANALOG_OFS);                   // [RULE5]
                8'h0C: cfg_byte = 8'(`FMR_TSTAMP_OFS >> 8);              // [RULE5]
                8'h0D: cfg_byte = 8'(`FMR_TSTAMP_OFS);                   // [RULE5]
                8'h0E: cfg_byte = 8'(`FMR_DIGITAL_OFS >> 8);             // [RULE5]
                8'h0F: cfg_byte = 8'(`FMR_DIGITAL_OFS);                  // [RULE5]
                8'hCE: cfg_byte = `FMR_LINE_ROT;                         // [RULE8]
                8'hCF: cfg_byte = `FMR_POWER_CALC;                       // [RULE8]
                // Deskew angle, source resistance and reactance: none
                8'hD0, 8'hD1: cfg_byte = `FMR_NOT_USED;                  // [RULE8]
                8'hD2, 8'hD3: cfg_byte = `FMR_NOT_USED;                  // [RULE8]
                8'hD4, 8'hD5: cfg_byte = `FMR_NOT_USED;                  // [RULE8]
                8'hD6: cfg_byte = `FMR_IDX_IA;                           // [RULE8]
                8'hD7: cfg_byte = `FMR_IDX_IB;                           // [RULE8]
                8'hD8: cfg_byte = `FMR_IDX_IC;                           // [RULE8]
                8'hD9: cfg_byte = `FMR_IDX_VA;                           // [RULE8]
                8'hDA: cfg_byte = `FMR_IDX_VB;                           // [RULE8]
                8'hDB: cfg_byte = `FMR_IDX_VC;                           // [RULE8]
                default: cfg_byte = `FMR_RESERVED;                       // [RULE8]
            endcase
        end
    endfunction

    // Request, sequencer and transmit state
    fmr_pkg::fmr_send_e  send_r;
    fmr_pkg::fmr_parse_e parse_r;
    logic       pend_cfg_r;
    logic       pend_dat_r;
    logic       blk_dat_r;
    logic [7:0] idx_r;
    logic [7:0] csum_r;
    logic [7:0] src_q_r;
    logic [7:0] tx_data_r;
    logic       tx_valid_r;
    logic       asc_ready_r;
    logic [7:0] src_addr_r;
    logic       src_rd_r;
    logic       burst_r;
    logic       tx_free;
    logic       seen_cfg;
    logic       seen_dat;
    logic       start;
    logic       load_bin;
    logic       load_asc;
    logic       last_byte;
    logic [7:0] bin_byte;

    // Request codes are decoded straight off the receiver
    assign tx_free   = !tx_valid_r || TX_READY;
    assign seen_cfg  = RX_VALID && parse_r == fmr_pkg::PARSE_CODE
                       && RX_DATA == `FMR_CFG_CODE;
    assign seen_dat  = RX_VALID && parse_r == fmr_pkg::PARSE_CODE
                       && RX_DATA == `FMR_DAT_CODE;
    // A burst never starts in a cycle where an ASCII byte may be taken
    assign start     = send_r == fmr_pkg::SEND_IDLE && !asc_ready_r
                       && (pend_cfg_r || pend_dat_r);
    assign load_bin  = send_r == fmr_pkg::SEND_LOAD && tx_free;
    assign load_asc  = asc_ready_r && ASCII_VALID;
    assign last_byte = blk_dat_r ? idx_r == `FMR_DAT_SUM_IDX
                                 : idx_r == `FMR_CFG_SUM_IDX;

    // Framing bytes are made here, data block payload comes from the source
    always_comb begin
        if (last_byte) begin
            bin_byte = csum_r;                                           // [RULE9]
        end else if (!blk_dat_r) begin
            bin_byte = cfg_byte(idx_r);
        end else if (idx_r == 8'h00) begin
            bin_byte = `FMR_SYNC_BYTE;                                   // [RULE10]
        end else if (idx_r == 8'h01) begin
            bin_byte = `FMR_DAT_CODE;                                    // [RULE10]
        end else if (idx_r == 8'h02) begin
            bin_byte = `FMR_DAT_LEN;                                     // [RULE10]
        end else if (idx_r == `FMR_DAT_RSV_IDX) begin
            bin_byte = `FMR_RESERVED;                                    // [RULE12]
        end else begin
            bin_byte = src_q_r;                                          // [RULE11] [RULE12]
        end
    end

    // Two-byte request decoder, most significant byte first
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            parse_r <= fmr_pkg::PARSE_SYNC;
        end else if (RX_VALID) begin
            if (RX_DATA == `FMR_SYNC_BYTE) begin
                parse_r <= fmr_pkg::PARSE_CODE;                          // [RULE15]
            end else begin
                parse_r <= fmr_pkg::PARSE_SYNC;
            end
        end
    end

    // Pending requests; a new request in the start cycle wins over the clear
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pend_cfg_r <= 1'b0;
            pend_dat_r <= 1'b0;
        end else begin
            pend_cfg_r <= seen_cfg || (pend_cfg_r && !start);
            pend_dat_r <= seen_dat || (pend_dat_r && !start);
        end
    end

    // Burst sequencer: fetch a payload byte, then load it into the transmitter
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            send_r     <= fmr_pkg::SEND_IDLE;
            blk_dat_r  <= 1'b0;
            idx_r      <= 8'h00;
            csum_r     <= 8'h00;
            src_addr_r <= 8'h00;
            src_rd_r   <= 1'b0;
            src_q_r    <= 8'h00;
        end else begin
            src_rd_r <= 1'b0;
            unique case (send_r)
                fmr_pkg::SEND_IDLE: begin
                    if (start) begin
                        blk_dat_r  <= pend_dat_r && !pend_cfg_r;
                        idx_r      <= 8'h00;
                        csum_r     <= 8'h00;
                        src_addr_r <= 8'h00;
                        src_rd_r   <= 1'b1;
                        send_r     <= fmr_pkg::SEND_FETCH;
                    end
                end
                // Source answers within the read cycle
                fmr_pkg::SEND_FETCH: begin
                    src_q_r <= SRC_DATA;
                    send_r  <= fmr_pkg::SEND_LOAD;
                end
                fmr_pkg::SEND_LOAD: begin
                    if (tx_free) begin
                        csum_r <= csum_r + bin_byte;                     // [RULE14]
                        if (last_byte) begin
                            send_r <= fmr_pkg::SEND_IDLE;                // [RULE13]
                        end else begin
                            idx_r      <= idx_r + 8'h01;
                            src_addr_r <= idx_r + 8'h01;
                            src_rd_r   <= 1'b1;
                            send_r     <= fmr_pkg::SEND_FETCH;
                        end
                    end
                end
                // A corrupted state code falls back to idle
                default: begin
                    send_r <= fmr_pkg::SEND_IDLE;
                end
            endcase
        end
    end

    // Burst flag kept in its own flop so the output carries no decode glitch
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            burst_r <= 1'b0;
        end else if (start) begin
            burst_r <= 1'b1;
        end else if (load_bin && last_byte) begin
            burst_r <= 1'b0;                                             // [RULE13]
        end
    end

    // ASCII bytes are offered only between bursts while the transmitter is empty
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            asc_ready_r <= 1'b0;
        end else if (asc_ready_r) begin
            asc_ready_r <= !ASCII_VALID && !pend_cfg_r && !pend_dat_r;   // [RULE13]
        end else begin
            asc_ready_r <= send_r == fmr_pkg::SEND_IDLE && !start && !tx_valid_r
                           && !pend_cfg_r && !pend_dat_r;
        end
    end

    // Transmit holding register shared by both streams
    // Both loads cannot meet: ASCII is offered only while the sequencer idles
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
        end else if (load_bin) begin
            tx_data_r  <= bin_byte;
            tx_valid_r <= 1'b1;
        end else if (load_asc) begin
            tx_data_r  <= ASCII_DATA;
            tx_valid_r <= 1'b1;
        end else if (TX_READY) begin
            tx_valid_r <= 1'b0;
        end
    end

    assign ASCII_READY  = asc_ready_r;
    assign TX_DATA      = tx_data_r;
    assign TX_VALID     = tx_valid_r;
    assign SRC_ADDR     = src_addr_r;
    assign SRC_RD       = src_rd_r;
    assign BURST_ACTIVE = burst_r;

endmodule

`default_nettype wire

/* testbench/fmr_framer_checker.sv */
// Checker for the fast meter response framer, bound to its ports.
// Assumes ASCII bytes never equal the sync byte A5.
`timescale 1ns/10ps
`default_nettype none

module fmr_framer_checker (
    input wire logic       REF_CLK,
    input wire logic       RESETN,
    input wire logic       ASCII_VALID,
    input wire logic       ASCII_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_VALID,
    input wire logic       TX_READY,
    input wire logic       BURST_ACTIVE,
    input wire logic [7:0] SRC_ADDR,
    input wire logic       SRC_RD
);
    logic       busy_r;
    logic       acc;
    logic [7:0] pos_r;
    logic [7:0] sum_r;
    logic [7:0] kind_r;
    logic [7:0] last;
    assign acc  = TX_VALID && TX_READY;
    assign last = (kind_r == 8'hC1) ? 8'hDD : 8'hE9;
    // Position and running sum of the block on the wire
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_r <= 1'b0;
            pos_r  <= 8'h00;
            sum_r  <= 8'h00;
            kind_r <= 8'h00;
        end else if (acc && !busy_r && BURST_ACTIVE && TX_DATA == 8'hA5) begin
            busy_r <= 1'b1;
            pos_r  <= 8'h01;
            sum_r  <= TX_DATA;
        end else if (acc && busy_r) begin
            busy_r <= (pos_r != last);
            pos_r  <= pos_r + 8'h01;
            sum_r  <= sum_r + TX_DATA;
            if (pos_r == 8'h01) begin
                kind_r <= TX_DATA;
            end
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    a_code_byte: assert property (busy_r && pos_r == 8'h01 && TX_VALID
        |-> TX_DATA inside {8'hC1, 8'hD1}) else $error("bad code byte");
    a_cfg_length: assert property (busy_r && pos_r == 8'h02 && kind_r == 8'hC1
        && TX_VALID |-> TX_DATA == 8'hDE) else $error("bad config length");
    a_dat_length: assert property (busy_r && pos_r == 8'h02 && kind_r == 8'hD1
        && TX_VALID |-> TX_DATA == 8'hEA) else $error("bad data length");
    a_sum_byte: assert property (busy_r && pos_r == last && TX_VALID
        |-> TX_DATA == sum_r) else $error("bad checksum");
    a_burst_span: assert property (busy_r && TX_VALID && pos_r != last
        |-> BURST_ACTIVE) else $error("burst flag dropped early");
    a_ascii_held: assert property (BURST_ACTIVE && $past(BURST_ACTIVE)
        |-> !ASCII_READY) else $error("ascii taken in burst");
    a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("tx byte not held");
    a_byte_pace: assert property (busy_r && acc && pos_r != last
        |=> TX_VALID or (!TX_VALID ##1 TX_VALID)) else $error("bad byte pacing");
    a_src_pulse: assert property (SRC_RD |-> BURST_ACTIVE ##1 !SRC_RD)
        else $error("source read not a single pulse in a burst");
    a_src_hold: assert property (!SRC_RD |-> $stable(SRC_ADDR))
        else $error("source address moved without a read");
    c_cfg_done: cover property (busy_r && acc && kind_r == 8'hC1 && pos_r == 8'hDD);
    c_dat_done: cover property (busy_r && acc && kind_r == 8'hD1 && pos_r == 8'hE9);
    c_ascii: cover property (ASCII_VALID && ASCII_READY);
endmodule

bind fmr_framer fmr_framer_checker fmr_framer_checker_inst (.REF_CLK, .RESETN,
    .ASCII_VALID, .ASCII_READY, .TX_DATA, .TX_VALID, .TX_READY, .BURST_ACTIVE,
    .SRC_ADDR, .SRC_RD);

`default_nettype wire

/* testbench/fmr_host_model.sv */
// Host master model: sends request codes and collects transmitted bytes.
// Assumes the bench supplies a random coin bit for stalls.
`timescale 1ns/10ps
`default_nettype none

module fmr_host_model (
    input  wire logic       REF_CLK,
    input  wire logic       slow,
    input  wire logic       coin,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid,
    output var  logic       tx_ready
);
    logic [7:0] got[$];
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    always @(posedge REF_CLK) tx_ready <= #1 !slow || coin;
    always @(negedge REF_CLK) if (tx_valid && tx_ready) got.push_back(tx_data);
    task automatic put(input logic [7:0] b);
        @(posedge REF_CLK);
        #1;
        rx_data  = b;
        rx_valid = 1'b1;
        @(posedge REF_CLK);
        #1;
        rx_data  = ~b;
        rx_valid = 1'b0;
    endtask
    // Sync byte first, then the code; caller waits for the whole reply
    task automatic send_req(input logic [7:0] code);
        put(8'hA5);
        put(code);
    endtask
endmodule

`default_nettype wire

/* testbench/fmr_framer_tb_top.sv */
// Self-checking bench for the fast meter response framer.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

module fmr_framer_tb_top;
    logic        REF_CLK, RESETN, RX_VALID, ASCII_VALID, ASCII_READY, TX_VALID;
    logic        TX_READY, SRC_RD, BURST_ACTIVE, slow, coin;
    logic [7:0]  RX_DATA, ASCII_DATA, TX_DATA, SRC_ADDR, SRC_DATA, dseed;
    logic [15:0] rnd = 16'hB7D9;
    logic [7:0]  blk[$];
    logic [15:0] rst_seen;
    int          miscompares = 0;
    int          n_tests = 0;

    // Payload source answers within the read cycle
    assign SRC_DATA = SRC_ADDR ^ dseed;

    fmr_framer fmr_framer_inst (.REF_CLK, .RESETN, .RX_DATA, .RX_VALID, .ASCII_DATA,
        .ASCII_VALID, .ASCII_READY, .TX_DATA, .TX_VALID, .TX_READY, .SRC_ADDR, .SRC_RD,
        .SRC_DATA, .BURST_ACTIVE);
    fmr_host_model fmr_host_model_inst (.REF_CLK, .slow, .coin, .tx_data(TX_DATA),
        .tx_valid(TX_VALID), .rx_data(RX_DATA), .rx_valid(RX_VALID), .tx_ready(TX_READY));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        rnd  <= lfsr(rnd);
        coin <= #1 rnd[3];
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (exp !== got) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    function automatic void mk_blk(input logic [7:0] code);
        string      nm[19] = '{"IA", "IB", "IC", "IP", "VA", "VB", "VC", "VS", "FREQ",
            "VBAT", "IAX", "IBX", "ICX", "IAY", "IBY", "ICY", "IAT", "IBT", "ICT"};
        logic [7:0] s;
        s = 8'h00;
        blk = {8'hA5, code};
        if (code == 8'hC1) begin
            blk = {blk, 8'hDE, 8'h01, 8'h00, 8'h00, 8'h13, 8'h02, 8'h44, 8'h01, 8'h00,
                8'h04, 8'h00, 8'h9C, 8'h00, 8'hA4};
            foreach (nm[i]) begin
                for (int k = 0; k < 6; k++) blk.push_back(k < nm[i].len() ? nm[i][k] : 8'h00);
                blk = {blk, 8'h01, 8'hFF, 8'h00, 8'h00};
            end
            blk = {blk, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
                8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h00};
        end else begin
            blk.push_back(8'hEA);
            for (int a = 3; a < 232; a++) blk.push_back(8'(a) ^ dseed);
            blk.push_back(8'h00);
        end
        foreach (blk[i]) s += blk[i];
        blk.push_back(s);
    endfunction

    // Block request, optionally amid ASCII traffic and after a stray code
    task automatic run(input logic [7:0] code, input int n_asc, input logic [7:0] pre,
                       input logic s);
        logic [7:0] asc[$];
        logic [7:0] e[$];
        int         i;
        int         k;
        int         n_got;
        @(posedge REF_CLK);
        #1;
        slow  = s;
        dseed = rnd[7:0];
        mk_blk(code);
        fmr_host_model_inst.got.delete();
        for (i = 0; i < n_asc; i++) asc.push_back({2'b01, rnd[13:8] ^ i[5:0]});
        fork
            begin
                foreach (asc[j]) begin
                    ASCII_DATA  = asc[j];
                    ASCII_VALID = 1'b1;
                    k = 0;
                    do begin
                        @(negedge REF_CLK);
                        k++;
                    end while (!ASCII_READY && k < 3000);
                    if (!ASCII_READY) begin
                        miscompares++;
                        stop_test();
                    end
                    @(posedge REF_CLK);
                    #1;
                end
                ASCII_VALID = 1'b0;
            end
            begin
                repeat (n_asc) @(posedge REF_CLK);
                if (pre != 8'h00) fmr_host_model_inst.send_req(pre);
                fmr_host_model_inst.send_req(code);
            end
        join
        for (k = 0; k < 8000 && fmr_host_model_inst.got.size() < blk.size() + n_asc; k++)
            @(posedge REF_CLK);
        if (k == 8000) begin
            miscompares++;
            stop_test();
        end
        repeat (20) @(posedge REF_CLK);
        n_got = fmr_host_model_inst.got.size();
        chk("byte count", 16'(blk.size() + n_asc), 16'(n_got));
        for (i = 0; i < n_asc && fmr_host_model_inst.got[i] !== 8'hA5; i++);
        foreach (asc[n]) if (n == i) e = {e, blk, asc[n]}; else e.push_back(asc[n]);
        if (i == n_asc) e = {e, blk};
        foreach (e[n]) chk("tx byte", 16'(e[n]), 16'(fmr_host_model_inst.got[n]));
        $display("test %0h done, mismatches %0d", code, miscompares);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        RESETN      = 1'b0;
        ASCII_DATA  = 8'h00;
        ASCII_VALID = 1'b0;
        slow        = 1'b0;
        dseed       = 8'h00;
        repeat (2) @(posedge REF_CLK);
        #1;
        rst_seen = {4'h0, TX_DATA, TX_VALID, BURST_ACTIVE, SRC_RD, ASCII_READY};
        chk("reset", 16'h0000, rst_seen);
        RESETN = 1'b1;
        run(8'hC1, 0, 8'h00, 1'b0);
        run(8'hD1, 0, 8'h00, 1'b1);
        run(8'hD1, 12, 8'hC0, 1'b1);
        run(8'hC1, 9, 8'hA5, 1'b1);
        repeat (4) run(rnd[0] ? 8'hC1 : 8'hD1, 5, 8'h00, 1'b1);
        stop_test();
    end
endmodule

`default_nettype wire
